// [design/sqcb_seq_top.sv]
// Program sequencer instruction cache control and branch unit
`timescale 1ns/10ps
`include "sqcb_defs.svh"
// Overview of operation
// [RQ1] Conflicting fetch is n+3, cache holds it
// [RQ2] Conflict hit delivers cached instruction, no stall
// [RQ3] Conflict miss refetches next cycle, one stall
// [RQ4] Miss fill only when enabled and unfrozen
// [RQ5] 64 entries, 32 sets, index addr[4:0]
// [RQ6] Per-set LRU bit names entry not last used
// [RQ7] Hit compares both entries, LRU points away
// [RQ8] Fill goes to LRU entry, then LRU inverts
// [RQ9] Reset: cache empty, unfrozen and enabled
// [RQ10] Bit 5 enables caching of DM conflicts
// [RQ11] Bit 6 freezes contents, no replacement
// [RQ12] Bit 7 enables caching of PM conflicts
// [RQ13] Software waits a cycle after cache enable; here enables act five cycles after the write
// [RQ14] Flush invalidates every cache entry
// [RQ15] Call pushes return address; jump does not
// [RQ16] Subroutine return pops PC; interrupt return also status
// [RQ17] Conditional branch taken only if condition true
// [RQ18] Immediate branch loses four, delayed two cycles
// [RQ19] Software: no branch as last loop instruction
// [RQ20] Direct targets absolute or 16-bit PC-relative
// [RQ21] Long jump and far call carry 24 bits
// [RQ22] Indirect targets come from an index register
// [RQ23] Indirect target: page byte over index bits
// [RQ24] Freeze bit change acts four cycles later
// [RQ25] Cache used on dual access or same 16K block
// [RQ26] Tag is full 24-bit address, exact match
module sqcb_seq_top #(
  parameter int PCS_DEPTH = 16,
  parameter int STS_W = 16,
  parameter int STS_DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Cache mode control register
  input wire logic ctl_wr_en,
  input wire logic [7:0] ctl_wr_data,
  output logic [7:0] ctl_rd_data,
  input wire logic flush_cache,
  // Indirect branch page register
  input wire logic page_wr_en,
  input wire logic [7:0] page_wr_data,
  output logic [7:0] page_rd_data,
  // Executing instruction and its data accesses
  input wire logic exec_vld,
  input wire logic [`SQCB_AW-1:0] exec_pc,
  input wire logic pm_acc,
  input wire logic dm_acc,
  input wire logic [`SQCB_AW-1:0] data_addr,
  // Fetch pipeline
  input wire logic fetch_req,
  input wire logic [`SQCB_AW-1:0] fetch_addr,
  output logic [`SQCB_IW-1:0] fetch_instr,
  output logic fetch_instr_vld,
  output logic fetch_stall,
  // Program memory over the PM bus
  output logic mem_rd_req,
  output logic [`SQCB_AW-1:0] mem_rd_addr,
  input wire logic [`SQCB_IW-1:0] mem_rd_data,
  // Branch request from the execute stage
  input wire logic br_vld,
  input wire sqcb_pkg::sqcb_br_op_t br_op,
  input wire sqcb_pkg::sqcb_br_src_t br_src,
  input wire logic br_cond,
  input wire logic br_cond_true,
  input wire logic delayed_branch_modifier,
  input wire logic [`SQCB_AW-1:0] br_imm,
  input wire logic [15:0] br_index,
  // Redirect and suppression
  output logic redir_vld,
  output logic [`SQCB_AW-1:0] redir_addr,
  output logic exec_suppress,
  // Stacks
  input wire logic sts_push,
  input wire logic [STS_W-1:0] sts_din,
  output logic [STS_W-1:0] sts_top,
  output logic pcs_empty,
  output logic pcs_full
);
  sqcb_pkg::sqcb_seq_st_t s_r, s_nxt;
  sqcb_cache_if #(.AW(`SQCB_AW), .IW(`SQCB_IW)) cif ();
  logic [`SQCB_AW-1:0] conf_addr;
  logic [`SQCB_AW-1:0] br_target;
  logic [`SQCB_AW-1:0] ret_addr;
  logic [`SQCB_AW-1:0] pcs_top;
  logic conflict;
  logic frz_eff;
  logic cde_eff;
  logic cpe_eff;
  logic miss_ena;
  logic take;
  logic pcs_push;
  logic pcs_pop;
  logic sts_pop;

  // Executing n collides with the fetch of n+3
  assign conf_addr = exec_pc + `SQCB_AHEAD; // RQ1
  assign frz_eff = s_r.frz_pipe[`SQCB_FRZ_LAT-1]; // RQ24
  assign cde_eff = s_r.cde_pipe[`SQCB_ENA_LAT-1];
  assign cpe_eff = s_r.cpe_pipe[`SQCB_ENA_LAT-1];
  assign miss_ena = s_r.miss_pm ? cpe_eff : cde_eff; // RQ10 RQ12

  // Cache needed on dual access or one access in the fetch block
  always_comb begin
    conflict = 1'b0;
    if (s_r.fsm == sqcb_pkg::SQCB_RUN && exec_vld) begin
      conflict = (pm_acc && dm_acc) ||
        ((pm_acc || dm_acc) && data_addr[`SQCB_BLK_MSB:`SQCB_BLK_LSB] ==
         conf_addr[`SQCB_BLK_MSB:`SQCB_BLK_LSB]); // RQ25
    end
  end

  // Cache lookup and fill
  assign cif.lkp_en = conflict;
  assign cif.lkp_addr = conf_addr; // RQ1
  assign cif.flush = flush_cache; // RQ14
  assign cif.fill_addr = s_r.miss_addr;
  assign cif.fill_instr = mem_rd_data;
  // Miss cycle writes only when enabled and not frozen
  assign cif.fill_en = (s_r.fsm == sqcb_pkg::SQCB_MISS) && miss_ena && !frz_eff; // RQ4 RQ11

  // PM bus: the missed fetch goes out one cycle after the access
  assign mem_rd_req = (s_r.fsm == sqcb_pkg::SQCB_MISS) ||
                      (fetch_req && !conflict);
  assign mem_rd_addr = (s_r.fsm == sqcb_pkg::SQCB_MISS) ? s_r.miss_addr : fetch_addr;
  assign fetch_stall = (s_r.fsm == sqcb_pkg::SQCB_MISS); // RQ3

  // Branch decode
  assign exec_suppress = (s_r.lost_cnt != 3'h0) &&
    (!s_r.lost_dly || s_r.lost_cnt <= `SQCB_LOST_DLY); // RQ18
  // Branches in suppressed slots or a stall cycle never act
  assign take = br_vld && !fetch_stall && (s_r.lost_cnt == 3'h0) &&
                (!br_cond || br_cond_true); // RQ17
  // Call return skips the two delay slots when delayed
  assign ret_addr = exec_pc + (delayed_branch_modifier ? `SQCB_RET_DLY : `SQCB_RET_IMM);
  assign pcs_push = take && br_op == sqcb_pkg::SQCB_CALL; // RQ15
  assign pcs_pop = take && (br_op == sqcb_pkg::SQCB_RTS || br_op == sqcb_pkg::SQCB_RTI); // RQ16
  assign sts_pop = take && br_op == sqcb_pkg::SQCB_RTI; // RQ16

  always_comb begin
    br_target = pcs_top; // RQ16
    if (br_op == sqcb_pkg::SQCB_JUMP || br_op == sqcb_pkg::SQCB_CALL) begin
      case (br_src)
        sqcb_pkg::SQCB_ABS: br_target = {exec_pc[23:16], br_imm[15:0]}; // RQ20
        sqcb_pkg::SQCB_PCREL: br_target = exec_pc + {{8{br_imm[15]}}, br_imm[15:0]}; // RQ20
        sqcb_pkg::SQCB_LONG: br_target = br_imm; // RQ21
        sqcb_pkg::SQCB_IND: br_target = {s_r.page, br_index}; // RQ22 RQ23
        default: br_target = br_imm;
      endcase
    end
  end

  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.instr_vld = 1'b0;
    s_nxt.redir_vld = 1'b0;
    if (ctl_wr_en) s_nxt.ctl = ctl_wr_data;
    if (page_wr_en) s_nxt.page = page_wr_data;
    // Mode bits reach the cache through latency pipes
    s_nxt.frz_pipe = {s_r.frz_pipe[`SQCB_FRZ_LAT-2:0], s_nxt.ctl[`SQCB_CFZ]}; // RQ24
    s_nxt.cde_pipe = {s_r.cde_pipe[`SQCB_ENA_LAT-2:0], s_nxt.ctl[`SQCB_CDE]}; // RQ10
    s_nxt.cpe_pipe = {s_r.cpe_pipe[`SQCB_ENA_LAT-2:0], s_nxt.ctl[`SQCB_CPE]}; // RQ12
    case (s_r.fsm)
      sqcb_pkg::SQCB_RUN: begin
        if (conflict) begin
          if (cif.hit) begin
            s_nxt.instr = cif.hit_instr; // RQ2
            s_nxt.instr_vld = 1'b1;
          end else begin
            s_nxt.fsm = sqcb_pkg::SQCB_MISS; // RQ3
            s_nxt.miss_addr = conf_addr;
            s_nxt.miss_pm = pm_acc;
          end
        end else if (fetch_req) begin
          s_nxt.instr = mem_rd_data;
          s_nxt.instr_vld = 1'b1;
        end
      end
      sqcb_pkg::SQCB_MISS: begin
        s_nxt.instr = mem_rd_data; // RQ3
        s_nxt.instr_vld = 1'b1;
        s_nxt.fsm = sqcb_pkg::SQCB_RUN;
      end
      default: s_nxt.fsm = sqcb_pkg::SQCB_RUN;
    endcase
    if (take) begin
      s_nxt.redir_vld = 1'b1;
      s_nxt.redir_addr = br_target;
      s_nxt.lost_cnt = `SQCB_LOST_IMM; // RQ18
      s_nxt.lost_dly = delayed_branch_modifier;
    end else if (s_r.lost_cnt != 3'h0) begin
      s_nxt.lost_cnt = s_r.lost_cnt - 3'h1;
    end
    if (sys_rst) begin
      s_nxt.fsm = sqcb_pkg::SQCB_RUN;
      s_nxt.ctl = `SQCB_CTL_RESET; // RQ9
      s_nxt.frz_pipe = '0;
      s_nxt.cde_pipe = '1;
      s_nxt.cpe_pipe = '1;
      s_nxt.page = `SQCB_PAGE_RESET; // RQ23
      s_nxt.miss_addr = '0;
      s_nxt.miss_pm = 1'b0;
      s_nxt.instr = '0;
      s_nxt.instr_vld = 1'b0;
      s_nxt.lost_cnt = 3'h0;
      s_nxt.lost_dly = 1'b0;
      s_nxt.redir_vld = 1'b0;
      s_nxt.redir_addr = '0;
    end
  end

  always_ff @(posedge mclk) begin
    s_r <= s_nxt;
  end

  assign ctl_rd_data = s_r.ctl;
  assign page_rd_data = s_r.page;
  assign fetch_instr = s_r.instr;
  assign fetch_instr_vld = s_r.instr_vld;
  assign redir_vld = s_r.redir_vld;
  assign redir_addr = s_r.redir_addr;

  sqcb_cache_array #(
    .SETS(`SQCB_SETS),
    .AW(`SQCB_AW),
    .IW(`SQCB_IW)
  ) u_cache (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .cif(cif)
  );

  sqcb_lifo #(
    .W(`SQCB_AW),
    .DEPTH(PCS_DEPTH)
  ) u_pc_stack (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .push(pcs_push),
    .pop(pcs_pop),
    .din(ret_addr),
    .top(pcs_top),
    .empty(pcs_empty),
    .full(pcs_full)
  );

  // Status entries pushed by interrupt entry logic outside
  sqcb_lifo #(
    .W(STS_W),
    .DEPTH(STS_DEPTH)
  ) u_sts_stack (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .push(sts_push),
    .pop(sts_pop),
    .din(sts_din),
    .top(sts_top),
    .empty(),
    .full()
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  chk_conflict_ahead: assert property ( // RQ1
    conflict && !cif.hit |=> fetch_stall && mem_rd_addr == $past(exec_pc) + `SQCB_AHEAD)
    else $error("miss refetch not at n+3");
  chk_hit_no_stall: assert property ( // RQ2
    conflict && cif.hit |=> !fetch_stall && fetch_instr_vld
    && fetch_instr == $past(cif.hit_instr)) else $error("cache hit stalled");
  chk_miss_one_stall: assert property ( // RQ3
    conflict && !cif.hit |=> fetch_stall && mem_rd_req ##1 !fetch_stall && fetch_instr_vld)
    else $error("miss stall not one cycle");
  // Checked against the register value itself, not the latency pipes
  chk_fill_gate_mode: assert property ( // RQ4
    cif.fill_en |-> fetch_stall && !$past(ctl_rd_data[`SQCB_CFZ], 3)
    && (s_r.miss_pm ? $past(ctl_rd_data[`SQCB_CPE], 4) : $past(ctl_rd_data[`SQCB_CDE], 4)))
    else $error("fill while disabled or frozen");
  chk_reset_modes: assert property (@(posedge mclk) disable iff (1'b0) // RQ9
    sys_rst |=> ctl_rd_data == `SQCB_CTL_RESET && !frz_eff && cde_eff && cpe_eff
    && page_rd_data == `SQCB_PAGE_RESET) else $error("bad reset modes");
  chk_freeze_latency: assert property ( // RQ24
    $past(ctl_wr_en, 4) |-> frz_eff == $past(ctl_wr_data[`SQCB_CFZ], 4))
    else $error("freeze latency wrong");
  chk_lost_immediate: assert property ( // RQ18
    take && !delayed_branch_modifier |=> exec_suppress [*4] ##1 !exec_suppress)
    else $error("immediate branch loss not four");
  chk_lost_delayed: assert property ( // RQ18
    take && delayed_branch_modifier |=> !exec_suppress [*2] ##1 exec_suppress [*2]
    ##1 !exec_suppress) else $error("delayed branch loss not two");
  chk_untaken_cond: assert property ( // RQ17
    br_vld && br_cond && !br_cond_true |=> !redir_vld) else $error("false cond taken");
  chk_call_push: assert property ( // RQ15
    pcs_push && !pcs_full |=> pcs_top == $past(ret_addr)) else $error("call push wrong");
  chk_indirect_page: assert property ( // RQ23
    take && br_op == sqcb_pkg::SQCB_JUMP && br_src == sqcb_pkg::SQCB_IND
    |=> redir_addr == {$past(s_r.page), $past(br_index)}) else $error("bad indirect target");
  chk_return_target: assert property ( // RQ16
    pcs_pop && !pcs_empty |=> redir_vld && redir_addr == $past(pcs_top))
    else $error("return target not stack top");
  chk_pcrel_target: assert property ( // RQ20
    take && br_op == sqcb_pkg::SQCB_JUMP && br_src == sqcb_pkg::SQCB_PCREL
    |=> redir_addr == $past(exec_pc) + {{8{$past(br_imm[15])}}, $past(br_imm[15:0])})
    else $error("bad relative target");

  cov_conflict_hit: cover property (conflict && cif.hit);
  cov_miss_fill: cover property (conflict && !cif.hit ##1 cif.fill_en);
  cov_delayed_call: cover property (take && br_op == sqcb_pkg::SQCB_CALL
    && delayed_branch_modifier);
  cov_int_return: cover property (take && br_op == sqcb_pkg::SQCB_RTI);
endmodule : sqcb_seq_top

// [design/sqcb_defs.svh]
// Constants for the sequencer cache and branch unit
`ifndef SQCB_DEFS_SVH
`define SQCB_DEFS_SVH
`define SQCB_AW 24
`define SQCB_IW 24
`define SQCB_SETS 32
`define SQCB_AHEAD 24'h000003
`define SQCB_BLK_MSB 23
`define SQCB_BLK_LSB 14
`define SQCB_CDE 5
`define SQCB_CFZ 6
`define SQCB_CPE 7
`define SQCB_CTL_RESET 8'hA0
`define SQCB_PAGE_RESET 8'h00
`define SQCB_FRZ_LAT 4
`define SQCB_ENA_LAT 5
`define SQCB_LOST_IMM 3'h4
`define SQCB_LOST_DLY 3'h2
`define SQCB_RET_IMM 24'h000001
`define SQCB_RET_DLY 24'h000003
`endif

// [design/sqcb_pkg.sv]
// Types for the sequencer cache and branch unit
`include "sqcb_defs.svh"
package sqcb_pkg;
  typedef enum logic [1:0] {SQCB_JUMP, SQCB_CALL, SQCB_RTS, SQCB_RTI} sqcb_br_op_t;
  typedef enum logic [1:0] {SQCB_ABS, SQCB_PCREL, SQCB_LONG, SQCB_IND} sqcb_br_src_t;
  typedef enum logic {SQCB_RUN, SQCB_MISS} sqcb_fsm_t;
  typedef struct packed {
    sqcb_fsm_t fsm;
    logic [7:0] ctl;
    logic [`SQCB_FRZ_LAT-1:0] frz_pipe;
    logic [`SQCB_ENA_LAT-1:0] cde_pipe;
    logic [`SQCB_ENA_LAT-1:0] cpe_pipe;
    logic [7:0] page;
    logic [`SQCB_AW-1:0] miss_addr;
    logic miss_pm;
    logic [`SQCB_IW-1:0] instr;
    logic instr_vld;
    logic [2:0] lost_cnt;
    logic lost_dly;
    logic redir_vld;
    logic [`SQCB_AW-1:0] redir_addr;
  } sqcb_seq_st_t;
endpackage : sqcb_pkg

// [design/sqcb_cache_if.sv]
// Lookup and fill path between controller and cache array
`timescale 1ns/10ps
interface sqcb_cache_if #(parameter int AW = 24, parameter int IW = 24);
  logic lkp_en;
  logic [AW-1:0] lkp_addr;
  logic hit;
  logic [IW-1:0] hit_instr;
  logic fill_en;
  logic [AW-1:0] fill_addr;
  logic [IW-1:0] fill_instr;
  logic flush;
  modport ctrl (output lkp_en, lkp_addr, fill_en, fill_addr, fill_instr, flush,
                input hit, hit_instr);
  modport array (input lkp_en, lkp_addr, fill_en, fill_addr, fill_instr, flush,
                 output hit, hit_instr);
endinterface : sqcb_cache_if

// [design/sqcb_lifo.sv]
// Small LIFO used for the return address and status stacks
`timescale 1ns/10ps
module sqcb_lifo #(
  parameter int W = 24,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Stack access
  input wire logic push,
  input wire logic pop,
  input wire logic [W-1:0] din,
  output logic [W-1:0] top,
  output logic empty,
  output logic full
);
  localparam int PW = $clog2(DEPTH) + 1;
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] cnt;
  } sqcb_lifo_st_t;
  sqcb_lifo_st_t s_r, s_nxt;
  assign empty = (s_r.cnt == '0);
  assign full = (s_r.cnt == PW'(DEPTH));
  assign top = empty ? '0 : s_r.mem[s_r.cnt - PW'(1)];
  always_comb begin
    s_nxt = s_r;
    if (sys_rst) begin
      s_nxt.cnt = '0;
    end else if (pop && !empty) begin
      // Pop with push replaces the top entry
      if (push) s_nxt.mem[s_r.cnt - PW'(1)] = din;
      else s_nxt.cnt = s_r.cnt - PW'(1);
    end else if (push && !full) begin
      s_nxt.mem[s_r.cnt] = din;
      s_nxt.cnt = s_r.cnt + PW'(1);
    end
  end
  always_ff @(posedge mclk) begin
    s_r <= s_nxt;
  end
  chk_lifo_push_count: assert property (@(posedge mclk) disable iff (sys_rst) // RQ15
    push && !pop && !full |=> s_r.cnt == $past(s_r.cnt) + PW'(1) && top == $past(din))
    else $error("stack push lost");
endmodule : sqcb_lifo

// [design/sqcb_cache_array.sv]
// Two-way set-associative instruction cache storage with LRU
`timescale 1ns/10ps
`include "sqcb_defs.svh"
module sqcb_cache_array #(
  parameter int SETS = `SQCB_SETS,
  parameter int AW = `SQCB_AW,
  parameter int IW = `SQCB_IW
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Controller side
  sqcb_cache_if.array cif
);
  localparam int IB = $clog2(SETS);
  typedef struct packed {
    logic [SETS-1:0][1:0] valid;
    logic [SETS-1:0] lru;
    logic [SETS-1:0][1:0][AW-1:0] tag;
    logic [SETS-1:0][1:0][IW-1:0] data;
  } sqcb_cache_st_t;
  sqcb_cache_st_t s_r, s_nxt;
  logic [IB-1:0] li, fi;
  logic [1:0] hv;
  logic fw;
  function automatic logic [IB-1:0] set_of(input logic [AW-1:0] a);
    return a[IB-1:0];
  endfunction : set_of
  always_comb begin
    li = set_of(cif.lkp_addr); // RQ5
    fi = set_of(cif.fill_addr); // RQ5
    fw = s_r.lru[fi];
    // Full address as tag, so a hit is an exact match
    for (int w = 0; w < 2; w++) begin
      hv[w] = s_r.valid[li][w] && (s_r.tag[li][w] == cif.lkp_addr); // RQ7 RQ26
    end
    cif.hit = |hv;
    cif.hit_instr = hv[1] ? s_r.data[li][1] : s_r.data[li][0];
    s_nxt = s_r;
    if (sys_rst || cif.flush) begin
      s_nxt.valid = '0; // RQ9 RQ14
      if (sys_rst) s_nxt.lru = '0;
    end else if (cif.fill_en) begin
      s_nxt.valid[fi][fw] = 1'b1; // RQ8
      s_nxt.tag[fi][fw] = cif.fill_addr;
      s_nxt.data[fi][fw] = cif.fill_instr;
      s_nxt.lru[fi] = ~fw;
    end else if (cif.lkp_en && cif.hit) begin
      s_nxt.lru[li] = hv[0]; // RQ6 RQ7
    end
  end
  always_ff @(posedge mclk) begin
    s_r <= s_nxt;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  chk_lru_after_hit: assert property ( // RQ7
    cif.lkp_en && cif.hit && !cif.fill_en && !cif.flush
    |=> s_r.lru[$past(li)] == $past(hv[0])) else $error("lru not updated on hit");
  chk_fill_lru_way: assert property ( // RQ8
    cif.fill_en && !cif.flush |=> s_r.valid[$past(fi)][$past(fw)]
    && s_r.lru[$past(fi)] != $past(fw)) else $error("fill missed lru entry");
  chk_flush_all: assert property ( // RQ14
    cif.flush |=> s_r.valid == '0 && !cif.hit) else $error("flush left entries");
endmodule : sqcb_cache_array

// [verification/sqcb_pm_model.sv]
// Program memory model answering PM bus reads in the same cycle
`timescale 1ns/10ps
module sqcb_pm_model (
  // Clock
  input wire logic mclk,
  // Read request
  input wire logic mem_rd_req,
  input wire logic [23:0] mem_rd_addr,
  // Content scrambler, changed to mimic rewritten program memory
  input wire logic [23:0] salt,
  // Read data
  output logic [23:0] mem_rd_data
);
  logic [23:0] junk_r = 24'hC35A96;
  // Idle bus shows a shifting pattern, never the last word
  always @(posedge mclk) junk_r <= {junk_r[22:0], ~junk_r[23]};
  assign mem_rd_data = mem_rd_req ? (mem_rd_addr ^ salt) : junk_r;
endmodule : sqcb_pm_model

// [verification/sqcb_seq_top_bench.sv]
// Self-checking bench for the sequencer cache and branch unit
`timescale 1ns/10ps
module sqcb_seq_top_bench;
  logic mclk, sys_rst, ctl_wr_en, flush_cache, page_wr_en, exec_vld, pm_acc, dm_acc;
  logic fetch_req, fetch_instr_vld, fetch_stall, mem_rd_req, br_vld, br_cond, br_cond_true;
  logic delayed_branch_modifier, redir_vld, exec_suppress, sts_push, pcs_empty, pcs_full;
  logic [7:0] ctl_wr_data, ctl_rd_data, page_wr_data, page_rd_data, pg;
  logic [23:0] exec_pc, data_addr, fetch_addr, fetch_instr, mem_rd_addr, mem_rd_data;
  logic [23:0] br_imm, redir_addr, salt, s_old;
  logic [15:0] br_index, sts_din, sts_top;
  sqcb_pkg::sqcb_br_op_t br_op;
  sqcb_pkg::sqcb_br_src_t br_src;
  integer seed, error_cnt, check_count;
  logic [23:0] ret_q[$];
  logic [15:0] sts_q[$];
  logic [23:0] lru_n [9] = '{24'h000002, 24'h000022, 24'h000002, 24'h000042, 24'h000002,
                             24'h000022, 24'h000002, 24'h000042, 24'h800002};
  logic [8:0] lru_h = 9'h054;
  logic [7:0] modes [5] = '{8'h00, 8'h20, 8'h80, 8'hE0, 8'hA0};

  sqcb_seq_top i_sqcb_seq_top (
    .mclk, .sys_rst, .ctl_wr_en, .ctl_wr_data, .ctl_rd_data, .flush_cache, .page_wr_en,
    .page_wr_data, .page_rd_data, .exec_vld, .exec_pc, .pm_acc, .dm_acc, .data_addr,
    .fetch_req, .fetch_addr, .fetch_instr, .fetch_instr_vld, .fetch_stall, .mem_rd_req,
    .mem_rd_addr, .mem_rd_data, .br_vld, .br_op, .br_src, .br_cond, .br_cond_true,
    .delayed_branch_modifier, .br_imm, .br_index, .redir_vld, .redir_addr, .exec_suppress,
    .sts_push, .sts_din, .sts_top, .pcs_empty, .pcs_full
  );
  sqcb_pm_model i_sqcb_pm_model (.mclk, .mem_rd_req, .mem_rd_addr, .salt, .mem_rd_data);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic wr_ctl(input logic [7:0] v);
    @(posedge mclk);
    ctl_wr_en <= 1'b1;
    ctl_wr_data <= v;
    @(posedge mclk);
    ctl_wr_en <= 1'b0;
    #1 chk("mode readback", 24'(v), 24'(ctl_rd_data));
    // Enables act five cycles late, so no access before then
    repeat (7) @(posedge mclk);
  endtask : wr_ctl

  task automatic flush;
    @(posedge mclk);
    flush_cache <= 1'b1;
    @(posedge mclk);
    flush_cache <= 1'b0;
  endtask : flush

  task automatic expect_conf(input logic [23:0] n, input logic pm, input logic dm,
                             input logic exp_hit, input logic [23:0] exp_ins);
    logic hit;
    @(posedge mclk);
    exec_vld <= 1'b1;
    exec_pc <= n;
    pm_acc <= pm;
    dm_acc <= dm;
    data_addr <= n + 24'h000003;
    @(posedge mclk);
    exec_vld <= 1'b0;
    #1 hit = (fetch_stall === 1'b0);
    chk("cache hit", 24'(exp_hit), 24'(hit));
    if (!hit) begin
      chk("miss read", 24'h000001, 24'(mem_rd_req));
      chk("miss address", n + 24'h000003, mem_rd_addr);
      @(posedge mclk);
      #1 chk("stall length", 24'h000000, 24'(fetch_stall));
    end
    chk("word valid", 24'h000001, 24'(fetch_instr_vld));
    chk("delivered word", exp_ins, fetch_instr);
  endtask : expect_conf

  task automatic push_sts;
    logic [15:0] v;
    v = 16'($random(seed));
    @(posedge mclk);
    sts_push <= 1'b1;
    sts_din <= v;
    @(posedge mclk);
    sts_push <= 1'b0;
    sts_q.push_back(v);
  endtask : push_sts

  function automatic logic [23:0] target(input sqcb_pkg::sqcb_br_src_t s,
      input logic [23:0] pc, input logic [23:0] imm, input logic [15:0] idx);
    case (s)
      sqcb_pkg::SQCB_ABS: return {pc[23:16], imm[15:0]};
      sqcb_pkg::SQCB_PCREL: return pc + {{8{imm[15]}}, imm[15:0]};
      sqcb_pkg::SQCB_LONG: return imm;
      default: return {pg, idx};
    endcase
  endfunction : target

  task automatic branch(input int k);
    sqcb_pkg::sqcb_br_op_t op;
    sqcb_pkg::sqcb_br_src_t src;
    logic [23:0] pc, imm, exp;
    logic [15:0] idx;
    logic [1:0] r;
    logic cnd, ct, dly, tk, ret;
    r = k < 16 ? k[1:0] : 2'($random(seed));
    op = sqcb_pkg::sqcb_br_op_t'(r);
    r = k < 16 ? k[3:2] : 2'($random(seed));
    src = sqcb_pkg::sqcb_br_src_t'(r);
    ret = op inside {sqcb_pkg::SQCB_RTS, sqcb_pkg::SQCB_RTI};
    if (ret && ret_q.size() == 0) op = sqcb_pkg::SQCB_CALL;
    if (op == sqcb_pkg::SQCB_CALL && ret_q.size() > 11) op = sqcb_pkg::SQCB_RTS;
    ret = op inside {sqcb_pkg::SQCB_RTS, sqcb_pkg::SQCB_RTI};
    pc = 24'($random(seed));
    imm = 24'($random(seed));
    idx = 16'($random(seed));
    {cnd, ct, dly} = 3'($random(seed));
    tk = !cnd || ct;
    exp = ret ? ret_q[$] : target(src, pc, imm, idx);
    if (op == sqcb_pkg::SQCB_RTI) push_sts();
    @(posedge mclk);
    br_vld <= 1'b1;
    br_op <= op;
    br_src <= src;
    br_cond <= cnd;
    br_cond_true <= ct;
    delayed_branch_modifier <= dly;
    exec_pc <= pc;
    br_imm <= imm;
    br_index <= idx;
    @(posedge mclk);
    br_vld <= 1'b0;
    #1 chk("redirect", 24'(tk), 24'(redir_vld));
    if (tk) begin
      chk("branch target", exp, redir_addr);
      if (op == sqcb_pkg::SQCB_CALL) ret_q.push_back(pc + (dly ? 24'h000003 : 24'h000001));
      if (ret) void'(ret_q.pop_back());
      if (op == sqcb_pkg::SQCB_RTI) void'(sts_q.pop_back());
    end
    chk("stack empty", 24'(ret_q.size() == 0), 24'(pcs_empty));
    chk("stack full", 24'(ret_q.size() == 16), 24'(pcs_full));
    chk("status top", 24'(sts_q[$]), 24'(sts_top));
    for (int c = 1; c <= 4; c++) begin
      chk("suppress", 24'(tk && (!dly || c > 2)), 24'(exec_suppress));
      @(posedge mclk);
      #1;
    end
  endtask : branch

  initial begin
    repeat (100000) @(posedge mclk);
    error_cnt = error_cnt + 1;
    wrap_up();
  end

  initial begin
    seed = 32'h67AD;
    error_cnt = 0;
    check_count = 0;
    {ctl_wr_en, flush_cache, page_wr_en, exec_vld, pm_acc, dm_acc, fetch_req} = '0;
    {br_vld, br_cond, br_cond_true, delayed_branch_modifier, sts_push} = '0;
    {ctl_wr_data, page_wr_data, br_index, sts_din} = '0;
    {exec_pc, data_addr, fetch_addr, br_imm} = '0;
    salt = 24'h5A0F33;
    br_op = sqcb_pkg::SQCB_JUMP;
    br_src = sqcb_pkg::SQCB_ABS;
    sys_rst = 1'b1;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    #1 chk("mode reset", 24'h0000A0, 24'(ctl_rd_data));
    chk("page reset", 24'h000000, 24'(page_rd_data));
    chk("stack reset", 24'h000001, 24'(pcs_empty));
    expect_conf(24'h000100, 1'b1, 1'b1, 1'b0, 24'h000103 ^ salt);
    s_old = salt;
    @(posedge mclk);
    salt <= salt ^ 24'hFFFF00;
    expect_conf(24'h000100, 1'b1, 1'b1, 1'b1, 24'h000103 ^ s_old);
    flush();
    expect_conf(24'h000100, 1'b1, 1'b1, 1'b0, 24'h000103 ^ salt);
    $display("test basic conflict done");
    // Single data access in another 16K block is no conflict
    @(posedge mclk);
    exec_vld <= 1'b1;
    exec_pc <= 24'h000200;
    {pm_acc, dm_acc} <= 2'h1;
    data_addr <= 24'h004203;
    fetch_req <= 1'b1;
    fetch_addr <= 24'h000203;
    #1 chk("fetch address", 24'h000203, mem_rd_addr);
    @(posedge mclk);
    exec_vld <= 1'b0;
    fetch_req <= 1'b0;
    #1 chk("no stall", 24'h000000, 24'(fetch_stall));
    chk("fetch word", 24'h000203 ^ salt, fetch_instr);
    expect_conf(24'h000200, 1'b1, 1'b0, 1'b0, 24'h000203 ^ salt);
    $display("test block compare done");
    for (int i = 0; i < 9; i++) begin
      expect_conf(lru_n[i], 1'b1, 1'b0, lru_h[i], (lru_n[i] + 24'h000003) ^ salt);
    end
    // Mid-run reset must drop the entry just filled
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    expect_conf(24'h800002, 1'b1, 1'b0, 1'b0, 24'h800005 ^ salt);
    $display("test replacement done");
    foreach (modes[m]) begin
      wr_ctl(modes[m]);
      for (int p = 0; p < 2; p++) begin
        flush();
        expect_conf(24'h000300, p[0], !p[0], 1'b0, 24'h000303 ^ salt);
        expect_conf(24'h000300, p[0], !p[0], (p[0] ? modes[m][7] : modes[m][5]) &&
                    !modes[m][6], 24'h000303 ^ salt);
      end
    end
    $display("test cache modes done");
    pg = 8'($random(seed));
    @(posedge mclk);
    page_wr_en <= 1'b1;
    page_wr_data <= pg;
    @(posedge mclk);
    page_wr_en <= 1'b0;
    #1 chk("page readback", 24'(pg), 24'(page_rd_data));
    push_sts();
    for (int k = 0; k < 80; k++) branch(k);
    $display("test branches done");
    wrap_up();
  end
endmodule : sqcb_seq_top_bench
